// ==== rtl/itd_top.sv ====
// Purpose: control of a per-pin input delay line with 32 taps
// Assumes: ctrl_clk and the fabric controls arrive asynchronously to pclk
// Notes: software sets mode, source, preset and polarity over APB
`timescale 1ns/1ps
`include "itd_cfg.svh"
module itd_top
  import itd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ctrl_clk,
  input wire logic staging_clear,
  input wire logic tap_load_strobe,
  input wire logic step_enable,
  input wire logic step_up,
  input wire logic staging_capture,
  input wire logic [4:0] tap_value_load_bus,
  input wire logic pad_data_in,
  input wire logic fabric_data_in,
  output logic delayed_out,
  output logic [4:0] tap_value_report
);
  logic [31:0] cfg;
  logic [31:0] next_cfg;
  logic acc;
  logic cfg_wr;
  logic [10:0] ctl_raw;
  logic [10:0] ctl;
  logic [1:0] dat;
  logic s_clk;
  logic s_clr;
  logic s_load;
  logic s_ce;
  logic s_up;
  logic s_cap;
  itd_tap_t s_bus;
  logic pol;
  logic pol_prev;
  logic tick;
  itd_mode_e mode;
  itd_tap_t preset;
  logic src_fabric;
  logic fab_inv;
  logic pol_flip;
  itd_tap_t tap;
  itd_tap_t staging;
  logic line_in;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction : hit

  function automatic itd_tap_t tap_step(input itd_tap_t t, input logic up);
    // Natural 5-bit overflow gives the wraparound at both ends
    tap_step = up ? 5'(t + 5'h01) : 5'(t - 5'h01);
  endfunction : tap_step

  function automatic itd_tap_t mode_start(input itd_mode_e m,
                                          input itd_tap_t p);
    mode_start = (m == MODE_STATIC || m == MODE_STEP) ? p : `ITD_TAP_ZERO;
  endfunction : mode_start

  assign mode = itd_mode_e'(cfg[`ITD_MODE_LSB +: 2]);
  assign preset = cfg[`ITD_PRESET_LSB +: 5];
  assign src_fabric = cfg[`ITD_SRC_BIT];
  assign fab_inv = cfg[`ITD_INV_BIT];
  assign pol_flip = cfg[`ITD_FLIP_BIT];

  // APB: one wait state, so every output is registered
  assign acc = psel && penable && pready;
  assign cfg_wr = acc && pwrite && hit(paddr, `ITD_CFG_OFS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (hit(paddr, `ITD_CFG_OFS))
      begin
        if (!pwrite)
          prdata <= cfg;
      end
      else if (hit(paddr, `ITD_STAT_OFS))
      begin
        // Status is read only; a write there is refused
        pslverr <= pwrite;
        if (!pwrite)
        begin
          prdata[4:0] <= tap;
          prdata[`ITD_STAT_STAGE_LSB +: 5] <= staging;
          prdata[`ITD_STAT_MODE_LSB +: 2] <= mode;
        end
      end
      else
        pslverr <= 1'b1;
    end
  end

  always_comb
  begin
    next_cfg = cfg;
    for (int i = 0; i < 4; i++)
    begin
      if (pstrb[i])
        next_cfg[i*8 +: 8] = pwdata[i*8 +: 8];
    end
    next_cfg = next_cfg & `ITD_CFG_MASK;
  end

  // R22 preset field holds 0 to 31
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg <= `ITD_CFG_RST;
    else if (cfg_wr)
      cfg <= next_cfg;
  end

  // R03 controls cross into pclk first
  assign ctl_raw = {ctrl_clk, staging_clear, tap_load_strobe, step_enable,
                    step_up, staging_capture, tap_value_load_bus};

  itd_sync #(
    .W(11)
  ) u_ctl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(ctl_raw),
    .q(ctl)
  );

  itd_sync #(
    .W(2)
  ) u_dat_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({pad_data_in, fabric_data_in}),
    .q(dat)
  );

  assign s_clk = ctl[10];
  assign s_clr = ctl[9];
  assign s_load = ctl[8];
  assign s_ce = ctl[7];
  assign s_up = ctl[6];
  assign s_cap = ctl[5];
  assign s_bus = ctl[4:0];

  // R16 flip inverts the sensed control clock
  assign pol = s_clk ^ pol_flip;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pol_prev <= 1'b0;
    else
      pol_prev <= pol;
  end

  // R17 a flip may fake one edge; fabric keeps controls idle then
  // R04 no ticks without a running control clock
  assign tick = pol && !pol_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      staging <= `ITD_TAP_ZERO;
    // R25 reconfiguration empties staging
    else if (cfg_wr)
      staging <= `ITD_TAP_ZERO;
    else if (tick)
    begin
      // R10 clear only acts in staged-load mode
      if (s_clr && mode == MODE_PIPE)
        staging <= `ITD_TAP_ZERO;
      // R09 capture copies the load bus
      else if (s_cap)
        staging <= s_bus;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tap <= `ITD_TAP_ZERO;
    // R21 R23 R25 start value follows the new mode
    else if (cfg_wr)
      tap <= mode_start(itd_mode_e'(next_cfg[`ITD_MODE_LSB +: 2]),
                        next_cfg[`ITD_PRESET_LSB +: 5]);
    // R15 static mode never moves
    else if (tick && mode != MODE_STATIC)
    begin
      // R24 load wins over step
      if (s_load)
      begin
        case (mode)
          // R05 R06 back to preset, zero by default
          MODE_STEP: tap <= preset;
          // R07 direct load from the bus
          MODE_LOAD: tap <= s_bus;
          // R08 staged load from staging
          MODE_PIPE: tap <= staging;
          default: tap <= tap;
        endcase
      end
      // R11 R13 R14 one wrapping step per sampled edge
      else if (s_ce)
        tap <= tap_step(tap, s_up);
      // R12 without enable the tap holds
    end
  end

  // R19 fabric data may be inverted; it only ever reaches delayed_out
  // R02 exactly one source feeds the line
  assign line_in = src_fabric ? (dat[0] ^ fab_inv) : dat[1];

  // R01 32 positions held in a 5-bit count
  itd_delay_line u_line (
    .pclk(pclk),
    .presetn(presetn),
    .din(line_in),
    .tap(tap),
    .dout(delayed_out)
  );

  // R18 report tracks the tap one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tap_value_report <= `ITD_TAP_ZERO;
    else
      tap_value_report <= tap;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic step_go;
  assign step_go = tick && mode != MODE_STATIC && !s_load && !cfg_wr && s_ce;

  // R11
  step_up_a: assert property (step_go && s_up |=> // R11
    tap == 5'($past(tap) + 5'h01))
    else $error("tap did not step up by one");

  // R11
  step_down_a: assert property (step_go && !s_up |=> // R11
    tap == 5'($past(tap) - 5'h01))
    else $error("tap did not step down by one");

  // R14
  wrap_up_a: assert property (step_go && s_up && tap == `ITD_TAP_MAX |=> // R14
    tap == `ITD_TAP_ZERO)
    else $error("tap did not wrap from 31 to 0");

  // R14
  wrap_down_a: assert property (step_go && !s_up && tap == `ITD_TAP_ZERO // R14
    |=> tap == `ITD_TAP_MAX)
    else $error("tap did not wrap from 0 to 31");

  // R12
  hold_idle_a: assert property (!tick && !cfg_wr |=> $stable(tap)) // R12
    else $error("tap moved without a control edge");

  // R15
  static_hold_a: assert property (mode == MODE_STATIC && !cfg_wr |=> // R15
    tap == preset)
    else $error("static tap left the preset");

  // R05
  load_preset_a: assert property (tick && !cfg_wr && s_load && // R05
    mode == MODE_STEP |=> tap == $past(preset))
    else $error("step mode load missed the preset");

  // R07
  load_bus_a: assert property (tick && !cfg_wr && s_load && // R07
    mode == MODE_LOAD |=> tap == $past(s_bus))
    else $error("direct load missed the bus value");

  // R08
  load_stage_a: assert property (tick && !cfg_wr && s_load && // R08
    mode == MODE_PIPE |=> tap == $past(staging))
    else $error("staged load missed the staging value");

  // R10
  stage_clear_a: assert property (tick && !cfg_wr && s_clr && // R10
    mode == MODE_PIPE |=> staging == `ITD_TAP_ZERO)
    else $error("staging not cleared");

  // R09
  stage_cap_a: assert property (tick && !cfg_wr && s_cap && // R09
    !(s_clr && mode == MODE_PIPE) |=> staging == $past(s_bus))
    else $error("staging did not capture the bus");

  // R18
  report_a: assert property (##1 tap_value_report == $past(tap)) // R18
    else $error("report does not follow the tap");

  // R23
  cfg_start_a: assert property (cfg_wr && // R23
    next_cfg[`ITD_MODE_LSB +: 2] >= 2'h2 |=> tap == `ITD_TAP_ZERO)
    else $error("load modes did not start at zero");

  apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("APB answer not after one wait");

  wrap_c: cover property (step_go && s_up && tap == `ITD_TAP_MAX);
  pipe_load_c: cover property (tick && s_load && mode == MODE_PIPE &&
    staging != `ITD_TAP_ZERO);
  load_vs_step_c: cover property (tick && s_load && s_ce &&
    mode == MODE_LOAD);
  bad_addr_c: cover property (acc && pslverr);
endmodule : itd_top

// ==== pkg/itd_cfg.svh ====
// Purpose: constants for the input tap delay control block
// Assumes: APB offsets are byte addresses, one aligned word per register
// Notes: field positions are bit indices inside the 32-bit words
// How it works
// R01: 32 tap positions, 5-bit count, wraps
// R02: output follows exactly one selected source
// R03: controls sampled only on control clock
// R04: fabric supplies running control clock
// R05: step mode load returns to preset
// R06: zero preset makes load a reset
// R07: direct-load mode loads tap from bus
// R08: staged-load mode loads tap from staging
// R09: capture high writes bus into staging
// R10: clear zeroes staging, staged-load mode only
// R11: step enable moves tap one per tick
// R12: no step enable, tap holds
// R13: stepping starts/stops on next edge
// R14: 31 up gives 0, 0 down gives 31
// R15: static mode ignores stepping
// R16: polarity flip inverts control clock sense
// R17: fabric idles two cycles after flip
// R18: current tap always reported
// R19: fabric data may invert, never to pad
// R20: fabric stages lanes, loads all together
// R21: static mode tap fixed at preset
// R22: preset 0 to 31, step start value
// R23: load modes start tap at zero
// R24: load beats step on same edge
// R25: staging zero, tap at mode start
`ifndef ITD_CFG_SVH
`define ITD_CFG_SVH
`define ITD_CFG_OFS 12'h000
`define ITD_STAT_OFS 12'h004
`define ITD_MODE_LSB 0
`define ITD_SRC_BIT 2
`define ITD_INV_BIT 3
`define ITD_FLIP_BIT 4
`define ITD_PRESET_LSB 8
`define ITD_CFG_MASK 32'h0000_1F1F
`define ITD_CFG_RST 32'h0000_0000
`define ITD_STAT_STAGE_LSB 8
`define ITD_STAT_MODE_LSB 16
`define ITD_TAP_MAX 5'h1F
`define ITD_TAP_ZERO 5'h00
`define ITD_TAPS 32
`endif

// ==== pkg/itd_pkg.sv ====
// Purpose: shared types of the input tap delay control block
// Assumes: mode field is two bits wide
// Notes: enum order matches the mode field encoding
package itd_pkg;
  typedef enum logic [1:0] {
    MODE_STATIC,
    MODE_STEP,
    MODE_LOAD,
    MODE_PIPE
  } itd_mode_e;
  typedef logic [4:0] itd_tap_t;
endpackage : itd_pkg

// ==== rtl/itd_sync.sv ====
// Purpose: two-flop synchroniser for a group of level inputs
// Assumes: bits of a group are stable together around control edges
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module itd_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : itd_sync

// ==== rtl/itd_delay_line.sv ====
// Purpose: tapped delay line, one pclk per tap
// Assumes: tap changes take effect on the next edge
// Notes: a tap jump may skip or repeat samples at the output
`timescale 1ns/1ps
`include "itd_cfg.svh"
module itd_delay_line
  import itd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  input wire itd_tap_t tap,
  output logic dout
);
  logic [`ITD_TAPS-1:0] chain;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chain <= '0;
      dout <= 1'b0;
    end
    else
    begin
      chain <= {chain[`ITD_TAPS-2:0], din};
      dout <= chain[tap];
    end
  end
endmodule : itd_delay_line

// ==== verif/itd_fabric_model.sv ====
// Purpose: fabric-side model driving the tap control inputs
// Assumes: caller enters right after a rising pclk edge
// Notes: load bus shows the inverse of its last value between actions
`timescale 1ns/1ps
module itd_fabric_model (
  input wire logic pclk,
  output logic ctrl_clk,
  output logic staging_clear,
  output logic tap_load_strobe,
  output logic step_enable,
  output logic step_up,
  output logic staging_capture,
  output logic [4:0] tap_value_load_bus
);
  initial
  begin
    ctrl_clk = 1'b0;
    {staging_clear, tap_load_strobe, step_enable} = 3'h0;
    {step_up, staging_capture} = 2'h0;
    tap_value_load_bus = 5'h0A;
  end
  task automatic act(input logic pulse, clr, load, en, up, cap,
                     input logic [4:0] bus);
    staging_clear <= clr;
    tap_load_strobe <= load;
    step_enable <= en;
    step_up <= up;
    staging_capture <= cap;
    tap_value_load_bus <= bus;
    repeat (4) @(posedge pclk);
    ctrl_clk <= pulse;
    repeat (8) @(posedge pclk);
    ctrl_clk <= 1'b0;
    repeat (8) @(posedge pclk);
    {staging_clear, tap_load_strobe, step_enable} <= 3'h0;
    {step_up, staging_capture} <= 2'h0;
    // Stale bus value must not look valid once released
    tap_value_load_bus <= ~bus;
    repeat (8) @(posedge pclk);
  endtask : act
endmodule : itd_fabric_model

// ==== verif/test_input_tap_delay_control.sv ====
// Purpose: self-checking bench for the input tap delay control block
// Assumes: one APB wait state, control ticks a few pclk after ctrl_clk
// Notes: expected tap and staging are tracked by bench functions
`timescale 1ns/1ps
`include "itd_cfg.svh"
module test_input_tap_delay_control
  import itd_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [3:0] pstrb;
  logic ctrl_clk, staging_clear, tap_load_strobe, step_enable, step_up;
  logic staging_capture, pad_data_in, fabric_data_in, delayed_out;
  logic [4:0] tap_value_load_bus, tap_value_report;
  int mismatches, compares, cycles;
  integer seed;
  itd_mode_e mode;
  itd_tap_t tap, stage, preset;
  itd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_clk(ctrl_clk), .staging_clear(staging_clear),
    .tap_load_strobe(tap_load_strobe), .step_enable(step_enable),
    .step_up(step_up), .staging_capture(staging_capture),
    .tap_value_load_bus(tap_value_load_bus), .pad_data_in(pad_data_in),
    .fabric_data_in(fabric_data_in), .delayed_out(delayed_out),
    .tap_value_report(tap_value_report));
  itd_fabric_model fab_u (.pclk(pclk), .ctrl_clk(ctrl_clk),
    .staging_clear(staging_clear), .tap_load_strobe(tap_load_strobe),
    .step_enable(step_enable), .step_up(step_up),
    .staging_capture(staging_capture),
    .tap_value_load_bus(tap_value_load_bus));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // One wait state: pready is seen on the second access edge
    chk("pready wait", 32'h2, 32'(n));
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask : apb
  task automatic set_cfg(input itd_mode_e m, input logic src, inv, fl,
                         input itd_tap_t p);
    apb(1'b1, `ITD_CFG_OFS, (32'(p) << `ITD_PRESET_LSB) |
        (32'(fl) << `ITD_FLIP_BIT) | (32'(inv) << `ITD_INV_BIT) |
        (32'(src) << `ITD_SRC_BIT) | 32'(m));
    mode = m;
    preset = p;
    stage = 5'h00;
    tap = (m == MODE_LOAD || m == MODE_PIPE) ? 5'h00 : p;
    // Two idle control periods cover a polarity change
    repeat (40) @(posedge pclk);
    chk("tap after config", 32'(tap), 32'(tap_value_report));
  endtask : set_cfg
  function automatic itd_tap_t nxt_tap(input logic load, en, up,
                                       input itd_tap_t bus);
    if (mode == MODE_STATIC) return tap;
    if (load)
      return mode == MODE_STEP ? preset : mode == MODE_LOAD ? bus : stage;
    if (en) return up ? tap + 5'h01 : tap - 5'h01;
    return tap;
  endfunction : nxt_tap
  function automatic itd_tap_t nxt_stage(input logic clr, cap,
                                         input itd_tap_t bus);
    if (clr && mode == MODE_PIPE) return 5'h00;
    return cap ? bus : stage;
  endfunction : nxt_stage
  task automatic op(input logic pulse, clr, load, en, up, cap,
                    input itd_tap_t bus);
    itd_tap_t t;
    t = pulse ? nxt_tap(load, en, up, bus) : tap;
    if (pulse) stage = nxt_stage(clr, cap, bus);
    tap = t;
    fab_u.act(pulse, clr, load, en, up, cap, bus);
    chk("tap_value_report", 32'(tap), 32'(tap_value_report));
    apb(1'b0, `ITD_STAT_OFS, 32'h0);
    chk("status", {14'h0, mode, 3'h0, stage, 3'h0, tap},
        rd & 32'h0003_1F1F);
  endtask : op
  initial
  begin
    seed = 32'h6C8B393C;
    {mismatches, compares, cycles} = '0;
    {presetn, psel, penable, pwrite, pad_data_in, fabric_data_in} = '0;
    {paddr, pwdata} = '0;
    pstrb = 4'hF;
    mode = MODE_STATIC;
    {tap, stage, preset} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("report after reset", 32'h0, 32'(tap_value_report));
    apb(1'b0, `ITD_CFG_OFS, 32'h0);
    chk("config reset", `ITD_CFG_RST, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, `ITD_STAT_OFS, 32'hFFFF_FFFF);
    chk("status write error", 32'h1, {31'h0, err});
    set_cfg(MODE_STATIC, 1'b0, 1'b0, 1'b0, 5'h05);
    op(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 5'h09);
    set_cfg(MODE_STEP, 1'b0, 1'b0, 1'b0, 5'h1E);
    op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 5'h00);
    op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 5'h00);
    op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 5'h00);
    op(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 5'h00);
    op(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 5'h00);
    op(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 5'h00);
    set_cfg(MODE_STEP, 1'b0, 1'b0, 1'b1, 5'h00);
    op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 5'h00);
    op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00);
    set_cfg(MODE_LOAD, 1'b0, 1'b0, 1'b0, 5'h11);
    op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 5'h1F);
    set_cfg(MODE_PIPE, 1'b0, 1'b0, 1'b0, 5'h07);
    op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 5'h15);
    op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 5'h03);
    op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 5'h0C);
    for (int i = 0; i < 48; i++)
    begin
      r = $random(seed);
      if (i % 8 == 0)
        set_cfg(itd_mode_e'(r[9:8]), 1'b0, 1'b0, r[10], r[15:11]);
      op(1'b1, r[0], r[1], r[2], r[3], r[4], r[20:16]);
    end
    pad_data_in <= 1'b1;
    fabric_data_in <= 1'b0;
    set_cfg(MODE_STEP, 1'b0, 1'b0, 1'b0, 5'h03);
    chk("delayed pad", 32'h1, {31'h0, delayed_out});
    set_cfg(MODE_STEP, 1'b1, 1'b0, 1'b0, 5'h03);
    chk("delayed fabric", 32'h0, {31'h0, delayed_out});
    set_cfg(MODE_STEP, 1'b1, 1'b1, 1'b0, 5'h03);
    chk("inverted fabric", 32'h1, {31'h0, delayed_out});
    summarize();
  end
endmodule : test_input_tap_delay_control
